// >>> logic/lcdc_driver_config.sv
`timescale 1ns/1ps
`default_nettype none
module lcdc_driver_config
  import lcdc_pkg::*;
#(
  parameter int FAST_DIV = FAST_DIV_CYC,
  parameter int SLOW_DIV = SLOW_DIV_CYC
)(
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,
  input  wire logic [7:0]  sfr_addr_in,
  input  wire logic [7:0]  sfr_wdata_in,
  input  wire logic        sfr_wr_in,
  input  wire logic        sfr_rd_in,
  input  wire logic        sleep_power_mode_in,
  output logic      [7:0]  sfr_rdata_out,
  output lcdc_drive_t      drive_out,
  output logic             lcd_clock_tick_out,
  output logic             blink_visible_out,
  output logic             shared_pin_common_three_out,
  output logic             shared_pin_common_two_out,
  output logic      [15:0] segment_pin_enable_out,
  output logic      [7:0]  screen_config_out,
  output logic      [7:0]  display_data_out [MEM_WORDS]
);

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [7:0] main_cfg_r;
  logic [7:0] clock_cfg_r;
  logic [7:0] seg_en_lo_r;
  logic [7:0] drive_cfg_r;
  logic [7:0] mem_ptr_r;
  logic [7:0] screen_cfg_r;
  logic [7:0] seg_en_hi_r;
  logic [7:0] mem_r [MEM_WORDS];
  logic [7:0] rdata_nxt;
  logic       wr_main;
  logic       data_clear;
  logic       clear_now;

  assign wr_main    = sfr_wr_in && (sfr_addr_in == ADDR_MAIN_CFG);
  assign data_clear = main_cfg_r[BIT_DATA_CLEAR];
  // the write that sets the clear bit empties the memory on the same edge,
  // so stale data never outlives the register write that asked for the clear
  assign clear_now  = data_clear || (wr_main && sfr_wdata_in[BIT_DATA_CLEAR]);

  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      main_cfg_r <= RST_MAIN_CFG;
    end
    else if (wr_main)
    begin
      main_cfg_r <= sfr_wdata_in;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      clock_cfg_r  <= RST_ZERO;
      seg_en_lo_r  <= RST_ZERO;
      drive_cfg_r  <= RST_ZERO;
      mem_ptr_r    <= RST_ZERO;
      screen_cfg_r <= RST_ZERO;
      seg_en_hi_r  <= RST_ZERO;
    end
    else if (sfr_wr_in)
    begin
      unique case (sfr_addr_in)
        ADDR_CLOCK_CFG:  clock_cfg_r  <= sfr_wdata_in;
        ADDR_SEG_EN_LO:  seg_en_lo_r  <= sfr_wdata_in;
        ADDR_DRIVE_CFG:  drive_cfg_r  <= sfr_wdata_in;
        ADDR_MEM_PTR:    mem_ptr_r    <= sfr_wdata_in;
        ADDR_SCREEN_CFG: screen_cfg_r <= sfr_wdata_in;
        ADDR_SEG_EN_HI:  seg_en_hi_r  <= sfr_wdata_in;
        default:         ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // display data memory, addressed through the pointer
  // ----------------------------------------------------------------
  // clear is level sensitive: it wins over a data write in the same cycle
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      for (int i = 0; i < MEM_WORDS; i++)
      begin
        mem_r[i] <= RST_ZERO;
      end
    end
    else if (clear_now)
    begin
      for (int i = 0; i < MEM_WORDS; i++)
      begin
        mem_r[i] <= RST_ZERO;
      end
    end
    else if (sfr_wr_in && (sfr_addr_in == ADDR_MEM_DATA))
    begin
      mem_r[mem_ptr_r[PTR_BITS-1:0]] <= sfr_wdata_in;
    end
  end

  always_comb
  begin
    rdata_nxt = RST_ZERO;
    unique case (sfr_addr_in)
      ADDR_MAIN_CFG:   rdata_nxt = main_cfg_r;
      ADDR_CLOCK_CFG:  rdata_nxt = clock_cfg_r;
      ADDR_SEG_EN_LO:  rdata_nxt = seg_en_lo_r;
      ADDR_DRIVE_CFG:  rdata_nxt = drive_cfg_r;
      ADDR_MEM_PTR:    rdata_nxt = mem_ptr_r;
      ADDR_MEM_DATA:   rdata_nxt = mem_r[mem_ptr_r[PTR_BITS-1:0]];
      ADDR_SCREEN_CFG: rdata_nxt = screen_cfg_r;
      ADDR_SEG_EN_HI:  rdata_nxt = seg_en_hi_r;
      default:         rdata_nxt = RST_ZERO;
    endcase
  end

  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sfr_rdata_out <= RST_ZERO;
    end
    else if (sfr_rd_in)
    begin
      sfr_rdata_out <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // base clock dividers
  // ----------------------------------------------------------------
  // both rates run all the time so blink timing does not depend on the selected base
  logic [19:0] fast_cnt_r;
  logic [19:0] slow_cnt_r;
  logic        fast_tick;
  logic        slow_tick;

  assign fast_tick = (fast_cnt_r == 20'(FAST_DIV - 1));
  assign slow_tick = (slow_cnt_r == 20'(SLOW_DIV - 1));

  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      fast_cnt_r <= 20'h00000;
    end
    else
    begin
      fast_cnt_r <= fast_tick ? 20'h00000 : fast_cnt_r + 20'h00001;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      slow_cnt_r <= 20'h00000;
    end
    else
    begin
      slow_cnt_r <= slow_tick ? 20'h00000 : slow_cnt_r + 20'h00001;
    end
  end

  logic display_active;
  assign display_active = main_cfg_r[BIT_DRIVER_ON] &&
                          !(sleep_power_mode_in && main_cfg_r[BIT_SLEEP_OFF]);
  // the reference for sleep operation is enabled elsewhere by software

  // base tick is gated by the driver enable so an idle panel sees no clock
  assign lcd_clock_tick_out = display_active &&
                              (main_cfg_r[BIT_BASE_CLK_SEL] ? slow_tick : fast_tick);

  // ----------------------------------------------------------------
  // blink
  // ----------------------------------------------------------------
  logic [1:0] blink_source;
  logic [1:0] blink_frequency;
  logic [8:0] half_period;
  logic [8:0] blink_cnt_r;
  logic       blink_phase_r;
  logic       blink_run;

  assign blink_source    = clock_cfg_r[7:6];
  assign blink_frequency = clock_cfg_r[5:4];
  assign blink_run       = main_cfg_r[BIT_BLINK_ON] && blink_source[1];

  always_comb
  begin
    half_period = HALF_2HZ;
    if (blink_source == BLK_PROG)
    begin
      unique case (blink_frequency)
        2'h0: half_period = HALF_1HZ;
        2'h1: half_period = HALF_P5HZ;
        2'h2: half_period = HALF_P33HZ;
        2'h3: half_period = HALF_P25HZ;
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      blink_cnt_r   <= 9'h000;
      blink_phase_r <= 1'b1;
    end
    else if (!blink_run)
    begin
      blink_cnt_r   <= 9'h000;
      blink_phase_r <= 1'b1;
    end
    else if (slow_tick)
    begin
      if (blink_cnt_r >= half_period - 9'h001)
      begin
        blink_cnt_r   <= 9'h000;
        blink_phase_r <= !blink_phase_r;
      end
      else
      begin
        blink_cnt_r <= blink_cnt_r + 9'h001;
      end
    end
  end

  always_comb
  begin
    blink_visible_out = display_active;
    if (main_cfg_r[BIT_BLINK_ON])
    begin
      unique case (blink_source)
        BLK_SW_OFF: blink_visible_out = 1'b0;
        BLK_SW_ON:  blink_visible_out = display_active;
        default:    blink_visible_out = display_active && blink_phase_r;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // drive configuration and pins
  // ----------------------------------------------------------------
  always_comb
  begin
    drive_out.display_active    = display_active;
    drive_out.base_clock_slow   = main_cfg_r[BIT_BASE_CLK_SEL];
    drive_out.bias_third        = main_cfg_r[BIT_BIAS_THIRD];
    drive_out.multiplex_level   = main_cfg_r[1:0];
    drive_out.charge_pump_on    = !drive_cfg_r[BIT_EXT_LADDER];
    drive_out.ladder_on         = drive_cfg_r[BIT_EXT_LADDER];
    drive_out.drive_level_field = drive_cfg_r[5:0];
    drive_out.frame_divider     = clock_cfg_r[3:0];
  end

  // reserved code 00 leaves both pins as segments; software must not write it
  assign shared_pin_common_two_out   = main_cfg_r[1];
  assign shared_pin_common_three_out = (main_cfg_r[1:0] == MUX_FOUR);
  assign segment_pin_enable_out      = {seg_en_hi_r, seg_en_lo_r};
  assign screen_config_out           = screen_cfg_r;

  always_comb
  begin
    for (int i = 0; i < MEM_WORDS; i++)
    begin
      display_data_out[i] = mem_r[i];
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  sequence main_write_s;
    wr_main;
  endsequence

  sequence clear_set_s;
    wr_main && sfr_wdata_in[BIT_DATA_CLEAR];
  endsequence

  main_readback_a: assert property (main_write_s ##1 !wr_main ##1 (sfr_rd_in && !wr_main &&
    sfr_addr_in == ADDR_MAIN_CFG) |=> sfr_rdata_out == $past(sfr_wdata_in, 3))
    else $error("main config readback mismatch");
  driver_gate_a: assert property (!main_cfg_r[BIT_DRIVER_ON] |-> !drive_out.display_active && !lcd_clock_tick_out)
    else $error("display active while driver disabled");
  clear_zero_a: assert property (clear_set_s |=> mem_r[0] == 8'h00 && mem_r[MEM_WORDS-1] == 8'h00)
    else $error("data not cleared");
  clear_hold_a: assert property (data_clear |=> display_data_out[mem_ptr_r[PTR_BITS-1:0]] == 8'h00)
    else $error("data write accepted during clear");
  sleep_off_a: assert property (sleep_power_mode_in && main_cfg_r[BIT_SLEEP_OFF] |-> !display_active)
    else $error("display on in sleep with sleep-off set");
  sleep_keep_a: assert property (!main_cfg_r[BIT_SLEEP_OFF] |-> display_active == main_cfg_r[BIT_DRIVER_ON])
    else $error("display state differs from enable");
  clock_sel_a: assert property (lcd_clock_tick_out && main_cfg_r[BIT_BASE_CLK_SEL] |-> slow_tick)
    else $error("wrong base clock rate");
  pump_ladder_a: assert property (drive_out.charge_pump_on != drive_out.ladder_on)
    else $error("pump and ladder both or neither on");
  pin_map_a: assert property (main_cfg_r[1:0] == MUX_TWO |-> !shared_pin_common_two_out && !shared_pin_common_three_out)
    else $error("shared pins not segments in two-way");
  pin_four_a: assert property (main_cfg_r[1:0] == MUX_FOUR |-> shared_pin_common_two_out && shared_pin_common_three_out)
    else $error("shared pins not commons in four-way");
  blink_off_a: assert property (main_cfg_r[BIT_BLINK_ON] && blink_source == BLK_SW_OFF |-> !blink_visible_out)
    else $error("software blink off shows display");
  blink_hold_a: assert property (blink_run && slow_tick && $stable(clock_cfg_r) &&
    blink_cnt_r < half_period - 9'h001 |=> $stable(blink_phase_r))
    else $error("blink phase toggled early");

endmodule : lcdc_driver_config
`default_nettype wire

// >>> logic/lcdc_pkg.sv
`default_nettype none
package lcdc_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_MAIN_CFG   = 8'h95;
  localparam logic [7:0] ADDR_CLOCK_CFG  = 8'h96;
  localparam logic [7:0] ADDR_SEG_EN_LO  = 8'h97;
  localparam logic [7:0] ADDR_DRIVE_CFG  = 8'h9c;
  localparam logic [7:0] ADDR_MEM_PTR    = 8'hac;
  localparam logic [7:0] ADDR_MEM_DATA   = 8'hae;
  localparam logic [7:0] ADDR_SCREEN_CFG = 8'hb1;
  localparam logic [7:0] ADDR_SEG_EN_HI  = 8'hed;

  localparam logic [7:0] RST_MAIN_CFG    = 8'h01;
  localparam logic [7:0] RST_ZERO        = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_DRIVER_ON      = 7;
  localparam int BIT_DATA_CLEAR     = 6;
  localparam int BIT_BLINK_ON       = 5;
  localparam int BIT_SLEEP_OFF      = 4;
  localparam int BIT_BASE_CLK_SEL   = 3;
  localparam int BIT_BIAS_THIRD     = 2;
  localparam int BIT_EXT_LADDER     = 6;
  localparam int BIT_LEVEL_RANGE    = 5;
  localparam int MEM_WORDS          = 16;
  localparam int PTR_BITS           = 4;

  localparam logic [1:0] MUX_RESERVED = 2'h0;
  localparam logic [1:0] MUX_TWO      = 2'h1;
  localparam logic [1:0] MUX_THREE    = 2'h2;
  localparam logic [1:0] MUX_FOUR     = 2'h3;

  localparam logic [1:0] BLK_SW_OFF   = 2'h0;
  localparam logic [1:0] BLK_SW_ON    = 2'h1;
  localparam logic [1:0] BLK_FIXED    = 2'h2;
  localparam logic [1:0] BLK_PROG     = 2'h3;

  // ----------------------------------------------------------------
  // timing: half periods of blink, in 128 hz ticks
  // ----------------------------------------------------------------
  localparam int CLK_HZ          = 100_000_000;
  localparam int BASE_FAST_HZ    = 2048;
  localparam int BASE_SLOW_HZ    = 128;
  localparam int FAST_DIV_CYC    = CLK_HZ / BASE_FAST_HZ;
  localparam int SLOW_DIV_CYC    = CLK_HZ / BASE_SLOW_HZ;
  localparam logic [8:0] HALF_2HZ   = 9'h020;
  localparam logic [8:0] HALF_1HZ   = 9'h040;
  localparam logic [8:0] HALF_P5HZ  = 9'h080;
  localparam logic [8:0] HALF_P33HZ = 9'h0c0;
  localparam logic [8:0] HALF_P25HZ = 9'h100;

  typedef struct packed {
    logic       display_active;
    logic       base_clock_slow;
    logic       bias_third;
    logic [1:0] multiplex_level;
    logic       charge_pump_on;
    logic       ladder_on;
    logic [5:0] drive_level_field;
    logic [3:0] frame_divider;
  } lcdc_drive_t;
endpackage : lcdc_pkg
`default_nettype wire

// >>> tb/lcdc_driver_config_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; \
  $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module lcdc_driver_config_test;
  import lcdc_pkg::*;
  // ----------------------------------------------------------------
  // clock, reset, design and glass
  // ----------------------------------------------------------------
  localparam int FD = 4;
  localparam int SD = 8;
  logic        clock_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        sleep = 1'b0;
  logic [7:0]  rdata;
  lcdc_drive_t drv;
  logic        tick;
  logic        vis;
  logic        common_line_3;
  logic        common_line_2;
  logic [15:0] seg_en;
  logic [7:0]  scr;
  logic [7:0]  mem [MEM_WORDS];
  logic [15:0] ticks;
  logic [2:0]  commons;
  int          failures = 0;
  int          n_checks = 0;
  always #5 clock_in = ~clock_in;
  lcdc_driver_config #(.FAST_DIV(FD), .SLOW_DIV(SD)) dut (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .sfr_addr_in(addr), .sfr_wdata_in(wdata), .sfr_wr_in(wr), .sfr_rd_in(rd), .sleep_power_mode_in(sleep),
    .sfr_rdata_out(rdata), .drive_out(drv), .lcd_clock_tick_out(tick), .blink_visible_out(vis),
    .shared_pin_common_three_out(common_line_3), .shared_pin_common_two_out(common_line_2), .segment_pin_enable_out(seg_en),
    .screen_config_out(scr), .display_data_out(mem));
  lcdc_panel_model panel (.clock_in(clock_in), .rst_n_in(rst_n_in), .drive_in(drv), .tick_in(tick),
    .common_line_3_in(common_line_3), .common_line_2_in(common_line_2), .tick_count_out(ticks), .commons_out(commons));
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock_in);
    wr    <= 1'b0;
    #1;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock_in);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock_in);
    rd   <= 1'b0;
    @(posedge clock_in);
    #1 d = rdata;
  endtask : rd_reg
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  logic [7:0] amap [8] = '{8'h95, 8'h96, 8'h97, 8'h9c, 8'hac, 8'hae, 8'hb1, 8'hed};
  task automatic t_regs;
    logic [7:0] d;
    for (int i = 0; i < 8; i++)
    begin
      rd_reg(amap[i], d);
      `CHK(d, (i == 0) ? 8'h01 : 8'h00)
    end
    `CHK({common_line_3, common_line_2, drv.display_active}, 3'h0)
    for (int i = 0; i < 8; i++)
    begin
      wr_reg(amap[i], (i == 0) ? 8'h1d : 8'h50 + i[7:0]);
      rd_reg(amap[i], d);
      `CHK(d, (i == 0) ? 8'h1d : 8'h50 + i[7:0])
    end
    `CHK(seg_en, 16'h5752)
    `CHK(drv.frame_divider, 4'h1)
    `CHK(scr, 8'h56)
    rd_reg(8'h98, d);
    `CHK(d, 8'h00)
    $display("test regs done");
  endtask : t_regs
  task automatic t_mux;
    logic [7:0] v;
    for (int k = 0; k < 2; k++)
      for (int m = 1; m < 4; m++)
      begin
        v = (k == 1) ? 8'h8c : 8'h80;
        wr_reg(8'h95, v | m[7:0]);
        `CHK(drv.multiplex_level, m[1:0])
        `CHK({drv.display_active, drv.base_clock_slow, drv.bias_third}, {1'b1, k[0], k[0]})
        `CHK({common_line_3, common_line_2}, {m == 3, m >= 2})
        `CHK(commons, 3'(m + 1))
      end
    $display("test mux done");
  endtask : t_mux
  task automatic t_ladder;
    wr_reg(8'h9c, 8'h25);
    `CHK({drv.charge_pump_on, drv.ladder_on, drv.drive_level_field}, {2'h2, 6'h25})
    wr_reg(8'h9c, 8'h5f);
    `CHK({drv.charge_pump_on, drv.ladder_on, drv.drive_level_field}, {2'h1, 6'h1f})
    $display("test ladder done");
  endtask : t_ladder
  task automatic t_clear;
    logic [7:0] d;
    wr_reg(8'hac, 8'h03);
    wr_reg(8'hae, 8'ha5);
    `CHK(mem[3], 8'ha5)
    wr_reg(8'h95, 8'h41);
    `CHK(mem[3], 8'h00)
    wr_reg(8'hae, 8'h33);
    `CHK(mem[3], 8'h00)
    rd_reg(8'hae, d);
    `CHK(d, 8'h00)
    wr_reg(8'h95, 8'h01);
    wr_reg(8'hae, 8'h33);
    `CHK(mem[3], 8'h33)
    $display("test clear done");
  endtask : t_clear
  task automatic t_sleep;
    wr_reg(8'h95, 8'h81); // software has the battery reference on before sleeping
    @(posedge clock_in) sleep <= 1'b1;
    @(posedge clock_in) #1;
    `CHK(drv.display_active, 1'b1)
    wr_reg(8'h95, 8'h91);
    `CHK(drv.display_active, 1'b0)
    @(posedge clock_in) sleep <= 1'b0;
    @(posedge clock_in) #1;
    `CHK(drv.display_active, 1'b1)
    $display("test sleep done");
  endtask : t_sleep
  task automatic t_tick;
    logic [7:0]  cfg [3] = '{8'h81, 8'h89, 8'h01};
    int          exp [3] = '{40 / FD, 40 / SD, 0};
    logic [15:0] t0;
    for (int i = 0; i < 3; i++)
    begin
      wr_reg(8'h95, cfg[i]);
      t0 = ticks;
      repeat (40) @(posedge clock_in);
      #1;
      `CHK(ticks - t0, 16'(exp[i]))
    end
    $display("test tick done");
  endtask : t_tick
  task automatic blink_gap(input logic [7:0] clk_cfg, input int half);
    logic v0;
    int   n;
    wr_reg(8'h96, clk_cfg);
    wr_reg(8'h95, 8'ha1);
    for (int p = 0; p < 2; p++)
    begin
      v0 = vis;
      n  = 0;
      while (vis === v0 && n < 5000)
      begin
        @(posedge clock_in) #1;
        n++;
      end
      if (n >= 5000)
      begin
        failures++;
        test_done();
      end
    end
    `CHK(n, half * SD)
  endtask : blink_gap
  task automatic t_blink;
    int half [4] = '{64, 128, 192, 256};
    blink_gap(8'h80, 32);
    for (int f = 0; f < 4; f++)
      blink_gap(8'hc0 | (f[7:0] << 4), half[f]);
    wr_reg(8'h96, 8'h00);
    repeat (3) @(posedge clock_in);
    #1;
    `CHK(vis, 1'b0)
    wr_reg(8'h96, 8'h40);
    repeat (3) @(posedge clock_in);
    #1;
    `CHK(vis, 1'b1)
    $display("test blink done");
  endtask : t_blink
  initial
  begin
    repeat (4) @(posedge clock_in);
    rst_n_in <= 1'b1;
    t_regs();
    t_mux();
    t_ladder();
    t_clear();
    t_sleep();
    t_tick();
    t_blink();
    test_done();
  end
endmodule : lcdc_driver_config_test
`default_nettype wire

// >>> tb/lcdc_panel_model.sv
`timescale 1ns/1ps
`default_nettype none
module lcdc_panel_model
  import lcdc_pkg::*;
(
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,
  input  wire lcdc_drive_t drive_in,
  input  wire logic        tick_in,
  input  wire logic        common_line_3_in,
  input  wire logic        common_line_2_in,
  output logic      [15:0] tick_count_out,
  output logic      [2:0]  commons_out
);
  // ----------------------------------------------------------------
  // glass side: counts base clock edges and common lines in use
  // ----------------------------------------------------------------
  // every tick is counted: one that escapes while the driver is off puts dc on the glass
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      tick_count_out <= 16'h0000;
    else if (tick_in)
      tick_count_out <= tick_count_out + 16'h0001;
  end
  assign commons_out = 3'h2 + {2'h0, common_line_2_in} + {2'h0, common_line_3_in};
endmodule : lcdc_panel_model
`default_nettype wire
